// ---- serial_port_map.svh ----
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SP_IDX_PCTRL 8'h87
`define SP_IDX_SCTRL 8'h98
`define SP_IDX_SDATA 8'h99
`define SP_IDX_GIVEN 8'hA0
`define SP_IDX_BCAST 8'hA1
`define SP_IDX_ISTAT 8'hA2
`define SP_IDX_ICLR 8'hA3
`define SP_IDX_IEN 8'hA4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SP_SC_MODE_HI 7
`define SP_SC_MODE_LO 6
`define SP_SC_MP 5
`define SP_SC_REN 4
`define SP_SC_TB8 3
`define SP_SC_RB8 2
`define SP_SC_TI 1
`define SP_SC_RI 0
`define SP_PC_DOUBLE 7
`define SP_PC_FEDE 6
`define SP_IS_TX 0
`define SP_IS_RX 1
`define SP_IS_FE 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SP_RST_SCTRL 8'h00
`define SP_RST_PCTRL 2'h0
`define SP_RST_GIVEN 8'h00
`define SP_RST_BCAST 8'hFF

// ----------------------------------------------------------------
// Rate divisors
// ----------------------------------------------------------------
`define SP_M0_DIV_SLOW 4'hC
`define SP_M0_DIV_FAST 4'h4
`define SP_OVS 4'hF
`define SP_OVS_MID 4'h7
`define SP_M2_PRE_SLOW 3'h4
`define SP_M2_PRE_FAST 3'h2
`define SP_T1_PRE_SLOW 3'h2
`define SP_T1_PRE_FAST 3'h1

`endif

// ---- serial_port_pkg.sv ----
package serial_port_pkg;

  // Serial mode select
  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00,
    MODE_ASYNC10 = 2'b01,
    MODE_ASYNC11_FIX = 2'b10,
    MODE_ASYNC11_T1 = 2'b11
  } mode_t;

  // Transmit sequencer
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SYNC = 2'b01,
    TX_ASYNC = 2'b11
  } tx_state_t;

  // Receive sequencer, Gray along idle-start-data-stop
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;

  // Control register fields as seen by software
  typedef struct packed {
    logic mode_high_or_frame_error;
    logic mode_low_bit;
    logic multiproc_filter_bit;
    logic rx_enable;
    logic ninth_tx_bit;
    logic ninth_rx_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } serial_control_t;

endpackage

// ---- serial_port_control.sv ----
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// Function
// - Two mode bits select sync or async framing
// - Mode 0 clock: divide by 12 or 4
// - Modes 1,3: timer overflow over 32 or 16
// - Mode 2: system clock over 64 or 32
// - Bit 7 reads frame error when detection on
// - Mode 1 filter: stop bit and address
// - Modes 2,3 filter: ninth bit and address
// - Receive enable bit gates async reception
// - Mode 0: enable rising edge starts one byte
// - Ninth transmit bit sent in modes 2,3
// - Ninth receive bit stores ninth or stop bit
// - Transmit done flag after last bit
// - Receive done flag after 8th bit in mode 0, stop bit in mode 1, ninth bit in modes 2,3
// - Done flags raise interrupt, software clears
// - Control register resets to zero
// - Data write starts transmit, read gives receive
// - Mode 1 frame: start, 8 data, stop
// - Bit 7 is mode bit or error flag
module serial_port_control
  import serial_port_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic t1_ovf,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  output logic irq
);
`include "serial_port_map.svh"

  generate
    if (ADDR_W < 10) begin : g_addr_check
      $error("ADDR_W too small for register map");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  serial_control_t sc_r;
  logic mode_hi_r;
  logic fe_r;
  logic double_r;
  logic fede_r;
  logic [7:0] given_r;
  logic [7:0] bcast_r;
  logic [2:0] istat_r;
  logic [2:0] ien_r;
  logic [7:0] rx_buf_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic txd_r;
  logic rxd_out_r;
  logic rxd_oe_r;
  mode_t mode;
  logic acc;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [2:0] pre_r;
  logic tick_r;
  logic [3:0] m0_cnt_r;
  logic m0_fall;
  logic m0_rise;
  tx_state_t tx_state_r;
  logic [10:0] tx_shift_r;
  logic [3:0] tx_bits_r;
  logic [3:0] tx_tick_r;
  logic tx_ev_r;
  rx_state_t rx_state_r;
  logic [8:0] rx_shift_r;
  logic [3:0] rx_bits_r;
  logic [3:0] rx_tick_r;
  logic rxd_prev_r;
  logic rx_ev_r;
  logic rb8_we_r;
  logic rb8_val_r;
  logic fe_ev_r;
  logic rx_sync_busy;
  logic [8:0] rx_next;
  logic [2:0] ev;

  // Register hit on a word address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // Multiprocessor acceptance of one received byte
  function automatic logic accept(input logic mp, input logic bit9, input logic [7:0] d,
                                  input logic [7:0] g, input logic [7:0] b);
    accept = !mp || (bit9 && ((d == g) || (d == b)));
  endfunction

  assign mode = mode_t'({mode_hi_r, sc_r.mode_low_bit});
  assign acc = psel && penable && !pready_r;
  assign wr_en = psel && penable && pready_r && pwrite;
  assign rx_sync_busy = (rx_state_r == RX_DATA) && (mode == MODE_SYNC);
  assign rx_next = {rxd_in, rx_shift_r[8:1]};
  assign ev = {fe_ev_r, rx_ev_r, tx_ev_r};

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read mux and address decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (hit(paddr, `SP_IDX_SCTRL)) begin
      rd_data[7:0] = sc_r;
      rd_data[7] = fede_r ? fe_r : mode_hi_r;
    end else if (hit(paddr, `SP_IDX_SDATA)) begin
      rd_data[7:0] = rx_buf_r;
    end else if (hit(paddr, `SP_IDX_PCTRL)) begin
      rd_data[`SP_PC_DOUBLE] = double_r;
      rd_data[`SP_PC_FEDE] = fede_r;
    end else if (hit(paddr, `SP_IDX_GIVEN)) begin
      rd_data[7:0] = given_r;
    end else if (hit(paddr, `SP_IDX_BCAST)) begin
      rd_data[7:0] = bcast_r;
    end else if (hit(paddr, `SP_IDX_ISTAT)) begin
      rd_data[2:0] = istat_r;
    end else if (hit(paddr, `SP_IDX_IEN)) begin
      rd_data[2:0] = ien_r;
    end else if (hit(paddr, `SP_IDX_ICLR)) begin
      rd_data = 32'h0000_0000;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One wait state, answer registered
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc && !rd_hit;
      if (acc && !pwrite) begin
        prdata_r <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  // Serial control; hardware set wins over software write
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sc_r <= `SP_RST_SCTRL;
      mode_hi_r <= 1'b0;
      fe_r <= 1'b0;
    end else begin
      if (wr_en && hit(paddr, `SP_IDX_SCTRL)) begin
        sc_r <= pwdata[7:0];
        if (fede_r) begin
          fe_r <= pwdata[`SP_SC_MODE_HI];
        end else begin
          mode_hi_r <= pwdata[`SP_SC_MODE_HI];
        end
      end
      if (fe_ev_r) begin
        fe_r <= 1'b1;
      end
      if (rb8_we_r) begin
        sc_r.ninth_rx_bit <= rb8_val_r;
      end
      if (tx_ev_r) begin
        sc_r.tx_done_flag <= 1'b1;
      end
      if (rx_ev_r) begin
        sc_r.rx_done_flag <= 1'b1;
      end
    end
  end

  // Rate control, address compare values
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      {double_r, fede_r} <= `SP_RST_PCTRL;
      given_r <= `SP_RST_GIVEN;
      bcast_r <= `SP_RST_BCAST;
    end else if (wr_en) begin
      if (hit(paddr, `SP_IDX_PCTRL)) begin
        double_r <= pwdata[`SP_PC_DOUBLE];
        fede_r <= pwdata[`SP_PC_FEDE];
      end else if (hit(paddr, `SP_IDX_GIVEN)) begin
        given_r <= pwdata[7:0];
      end else if (hit(paddr, `SP_IDX_BCAST)) begin
        bcast_r <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable and output
  // ----------------------------------------------------------------
  // Sticky events, write-one clear, set wins
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      istat_r <= 3'h0;
      ien_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      if (wr_en && hit(paddr, `SP_IDX_ICLR)) begin
        istat_r <= (istat_r & ~pwdata[2:0]) | ev;
      end else begin
        istat_r <= istat_r | ev;
      end
      if (wr_en && hit(paddr, `SP_IDX_IEN)) begin
        ien_r <= pwdata[2:0];
      end
      irq_r <= |(istat_r & ien_r);
    end
  end

  // ----------------------------------------------------------------
  // Rate generation
  // ----------------------------------------------------------------
  // Sixteen-times oversampling tick for async modes
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pre_r <= 3'h0;
      tick_r <= 1'b0;
    end else if (mode == MODE_ASYNC11_FIX) begin
      if (pre_r >= (double_r ? `SP_M2_PRE_FAST : `SP_M2_PRE_SLOW) - 3'h1) begin
        pre_r <= 3'h0;
        tick_r <= 1'b1;
      end else begin
        pre_r <= pre_r + 3'h1;
        tick_r <= 1'b0;
      end
    end else if (t1_ovf) begin
      if (pre_r >= (double_r ? `SP_T1_PRE_FAST : `SP_T1_PRE_SLOW) - 3'h1) begin
        pre_r <= 3'h0;
        tick_r <= 1'b1;
      end else begin
        pre_r <= pre_r + 3'h1;
        tick_r <= 1'b0;
      end
    end else begin
      tick_r <= 1'b0;
    end
  end

  // Mode 0 shift clock phase counter
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      m0_cnt_r <= 4'h0;
    end else if (m0_cnt_r >=
                 (sc_r.multiproc_filter_bit ? `SP_M0_DIV_FAST : `SP_M0_DIV_SLOW) - 4'h1) begin
      m0_cnt_r <= 4'h0;
    end else begin
      m0_cnt_r <= m0_cnt_r + 4'h1;
    end
  end

  assign m0_fall = (m0_cnt_r == 4'h0);
  assign m0_rise = (m0_cnt_r ==
                    (sc_r.multiproc_filter_bit ? `SP_M0_DIV_FAST : `SP_M0_DIV_SLOW) >> 1);

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Frame shifting and pin drive
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 11'h7FF;
      tx_bits_r <= 4'h0;
      tx_tick_r <= 4'h0;
      tx_ev_r <= 1'b0;
      txd_r <= 1'b1;
      rxd_out_r <= 1'b1;
      rxd_oe_r <= 1'b0;
    end else begin
      tx_ev_r <= 1'b0;
      case (tx_state_r)
        TX_IDLE: begin
          rxd_oe_r <= 1'b0;
          if (rx_sync_busy && m0_fall) begin
            txd_r <= 1'b0;
          end else if (m0_rise || !rx_sync_busy) begin
            txd_r <= 1'b1;
          end
          if (wr_en && hit(paddr, `SP_IDX_SDATA) && !rx_sync_busy) begin
            if (mode == MODE_SYNC) begin
              tx_shift_r <= {3'h7, pwdata[7:0]};
              tx_bits_r <= 4'h8;
              tx_state_r <= TX_SYNC;
            end else begin
              // Start, data LSB first, ninth or stop, stop
              tx_shift_r <= {1'b1, (mode == MODE_ASYNC10) ? 1'b1 : sc_r.ninth_tx_bit,
                             pwdata[7:0], 1'b0};
              tx_bits_r <= (mode == MODE_ASYNC10) ? 4'hA : 4'hB;
              tx_tick_r <= 4'h0;
              txd_r <= 1'b0;
              tx_state_r <= TX_ASYNC;
            end
          end
        end
        TX_SYNC: begin
          rxd_oe_r <= 1'b1;
          if (m0_fall) begin
            if (tx_bits_r != 4'h0) begin
              rxd_out_r <= tx_shift_r[0];
              tx_shift_r <= {1'b1, tx_shift_r[10:1]};
              tx_bits_r <= tx_bits_r - 4'h1;
              txd_r <= 1'b0;
            end else begin
              tx_ev_r <= 1'b1;
              rxd_oe_r <= 1'b0;
              tx_state_r <= TX_IDLE;
            end
          end else if (m0_rise) begin
            txd_r <= 1'b1;
          end
        end
        TX_ASYNC: begin
          if (tick_r) begin
            if (tx_tick_r == `SP_OVS) begin
              tx_tick_r <= 4'h0;
              if (tx_bits_r == 4'h1) begin
                tx_ev_r <= 1'b1;
                txd_r <= 1'b1;
                tx_state_r <= TX_IDLE;
              end else begin
                txd_r <= tx_shift_r[1];
                tx_shift_r <= {1'b1, tx_shift_r[10:1]};
                tx_bits_r <= tx_bits_r - 4'h1;
              end
            end else begin
              tx_tick_r <= tx_tick_r + 4'h1;
            end
          end
        end
        default: begin
          tx_state_r <= TX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Start detect, sampling, filtering and load
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_state_r <= RX_IDLE;
      rx_shift_r <= 9'h000;
      rx_bits_r <= 4'h0;
      rx_tick_r <= 4'h0;
      rxd_prev_r <= 1'b1;
      rx_buf_r <= 8'h00;
      rx_ev_r <= 1'b0;
      rb8_we_r <= 1'b0;
      rb8_val_r <= 1'b0;
      fe_ev_r <= 1'b0;
    end else begin
      rxd_prev_r <= rxd_in;
      rx_ev_r <= 1'b0;
      rb8_we_r <= 1'b0;
      fe_ev_r <= 1'b0;
      case (rx_state_r)
        RX_IDLE: begin
          rx_tick_r <= 4'h0;
          rx_bits_r <= 4'h0;
          if (mode == MODE_SYNC) begin
            // Enable written from 0 to 1 arms one byte
            if (wr_en && hit(paddr, `SP_IDX_SCTRL) && pwdata[`SP_SC_REN] &&
                !sc_r.rx_enable && !sc_r.rx_done_flag && tx_state_r == TX_IDLE) begin
              rx_state_r <= RX_DATA;
            end
          end else if (sc_r.rx_enable && rxd_prev_r && !rxd_in) begin
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          if (!sc_r.rx_enable) begin
            rx_state_r <= RX_IDLE;
          end else if (tick_r) begin
            if (rx_tick_r == `SP_OVS_MID) begin
              rx_tick_r <= 4'h0;
              rx_state_r <= rxd_in ? RX_IDLE : RX_DATA;
            end else begin
              rx_tick_r <= rx_tick_r + 4'h1;
            end
          end
        end
        RX_DATA: begin
          if (mode == MODE_SYNC) begin
            // Sample at rising shift clock edge
            if (m0_rise && !txd_r) begin
              rx_shift_r <= rx_next;
              rx_bits_r <= rx_bits_r + 4'h1;
              if (rx_bits_r == 4'h7) begin
                rx_buf_r <= rx_next[8:1];
                rx_ev_r <= 1'b1;
                rx_state_r <= RX_IDLE;
              end
            end
          end else if (!sc_r.rx_enable) begin
            rx_state_r <= RX_IDLE;
          end else if (tick_r) begin
            if (rx_tick_r == `SP_OVS) begin
              rx_tick_r <= 4'h0;
              rx_shift_r <= rx_next;
              rx_bits_r <= rx_bits_r + 4'h1;
              if (mode == MODE_ASYNC10 && rx_bits_r == 4'h7) begin
                rx_state_r <= RX_STOP;
              end else if (rx_bits_r == 4'h8) begin
                // Ninth bit sampled: decide load now
                rx_state_r <= RX_STOP;
                if (!sc_r.rx_done_flag &&
                    accept(sc_r.multiproc_filter_bit, rxd_in, rx_shift_r[8:1],
                           given_r, bcast_r)) begin
                  rx_buf_r <= rx_shift_r[8:1];
                  rb8_we_r <= 1'b1;
                  rb8_val_r <= rxd_in;
                  rx_ev_r <= 1'b1;
                end
              end
            end else begin
              rx_tick_r <= rx_tick_r + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (tick_r) begin
            if (rx_tick_r == `SP_OVS) begin
              rx_state_r <= RX_IDLE;
              fe_ev_r <= !rxd_in;
              if (mode == MODE_ASYNC10 && !sc_r.rx_done_flag &&
                  accept(sc_r.multiproc_filter_bit, rxd_in, rx_shift_r[8:1],
                         given_r, bcast_r)) begin
                rx_buf_r <= rx_shift_r[8:1];
                rb8_we_r <= 1'b1;
                rb8_val_r <= rxd_in;
                rx_ev_r <= 1'b1;
              end
            end else begin
              rx_tick_r <= rx_tick_r + 4'h1;
            end
          end
        end
        default: begin
          rx_state_r <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign txd = txd_r;
  assign rxd_out = rxd_out_r;
  assign rxd_oe = rxd_oe_r;
  assign irq = irq_r;

endmodule

// ---- serial_port_control_asserts.sv ----
`timescale 1ns/1ps
module serial_port_control_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic t1_ovf,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_reset_out;
    disable iff (1'b0) !nrst |=> txd && rxd_out && !rxd_oe && !irq && !pready;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not idle in reset");
  property p_one_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no ready after one wait");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than a cycle");
  property p_ready_cause;
    pready |-> $past(psel && penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without request");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_err_data;
    pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("refused read gives data");
  property p_sync_low;
    rxd_oe && $fell(txd) |-> !txd ##1 !txd;
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("shift clock low too short");
  property p_sync_stable;
    rxd_oe && $rose(txd) |-> $stable(rxd_out);
  endproperty
  a_sync_stable: assert property (p_sync_stable) else $error("data moved at clock rise");
  property p_irq_clear;
    $fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2) ||
      $past(pready && pwrite, 3);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq dropped by itself");
  // Main scenarios
  c_err: cover property (pslverr);
  c_sync: cover property ($rose(rxd_oe));
  c_irq: cover property ($rose(irq));
endmodule
bind serial_port_control serial_port_control_chk #(.ADDR_W(ADDR_W)) u_serial_port_control_chk (
  .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .t1_ovf(t1_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .irq(irq)
);

// ---- serial_peer.sv ----
`timescale 1ns/1ps
module serial_peer (
  input wire logic ref_clk,
  input wire logic txd,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  output logic rxd_in
);
  logic drv = 1'b1;
  int cyc = 0;
  // Line level, device wins while it drives
  assign rxd_in = rxd_oe ? rxd_out : drv;
  always @(posedge ref_clk) cyc++;
  // Async frame out, bit 0 first, idle high
  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      drv <= f[i];
      repeat (per) @(posedge ref_clk);
    end
    drv <= 1'b1;
  endtask
  // Sync byte in, bit changes on shift clock fall
  task automatic send_sync(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      drv <= d[i];
      @(posedge txd);
    end
    repeat (2) @(posedge ref_clk);
    drv <= ~d[7];
  endtask
  // Async frame capture at mid bit
  task automatic get(input int n, input int per, output logic [10:0] f);
    f = 11'h000;
    wait (txd === 1'b0);
    repeat (per / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (per) @(posedge ref_clk);
    end
  endtask
  // Sync capture on shift clock rise, period measured
  task automatic get_sync(output logic [7:0] d, output int per);
    int t0;
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      d[i] = rxd_out;
      if (i == 0) t0 = cyc;
    end
    per = (cyc - t0) / 7;
  endtask
endmodule

// ---- serial_port_control_tb.sv ----
`timescale 1ns/1ps
`include "serial_port_map.svh"
module serial_port_control_tb
  import serial_port_pkg::*;
;
  typedef struct packed {
    logic [1:0] mode;
    logic dbl;
    logic mp;
    logic ninth;
    logic [7:0] data;
    int per;
  } row_t;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic t1_ovf = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd_in;
  logic rxd_out;
  logic rxd_oe;
  logic txd;
  logic irq;
  logic [31:0] rdat;
  logic rerr;
  logic [10:0] f;
  logic [7:0] d;
  serial_control_t sc;
  row_t r;
  int per;
  int cyc = 0;
  int err_count = 0;
  int n_tests = 0;
  // Plain rows: mode, double, filter bit, ninth, data, bit period in clocks
  row_t rows [6] = '{
    '{2'b10, 1'b0, 1'b0, 1'b1, 8'hA5, 64}, '{2'b10, 1'b1, 1'b0, 1'b0, 8'h3C, 32},
    '{2'b11, 1'b0, 1'b0, 1'b1, 8'h81, 64}, '{2'b01, 1'b1, 1'b0, 1'b1, 8'h7E, 32},
    '{2'b00, 1'b0, 1'b0, 1'b0, 8'hC3, 12}, '{2'b00, 1'b0, 1'b1, 1'b0, 8'h5A, 4}};

  serial_port_control u_serial_port_control (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .t1_ovf(t1_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
    .irq(irq));
  serial_peer u_serial_peer (
    .ref_clk(ref_clk), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in));

  // ----------------------------------------------------------------
  // Clock, timer overflow, timeout
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Overflow pulse every second clock
  always @(posedge ref_clk) t1_ovf <= !t1_ovf;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, {24'h0, v});
  endtask
  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0);
    sc = rdat[7:0];
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Receive one frame at 64 clocks a bit, then read control
  task automatic rx_frame(input logic [10:0] fr, input int n);
    u_serial_peer.send(fr, n, 64);
    repeat (8) @(posedge ref_clk);
    rd(`SP_IDX_SCTRL);
  endtask
  task automatic summarize();
    $display("Checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    check("txd_idle", txd, 1'b1);
    rd(`SP_IDX_SCTRL);
    check("sctrl_rst", rdat, 32'h0);
    rd(`SP_IDX_BCAST);
    check("bcast_rst", rdat, 32'hFF);
    rd(8'hFF);
    check("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
    // Transmit rows, interrupt raised and cleared
    foreach (rows[i]) begin
      r = rows[i];
      wr(`SP_IDX_PCTRL, {r.dbl, 7'h00});
      wr(`SP_IDX_SCTRL, {r.mode, r.mp, 1'b0, r.ninth, 3'b000});
      wr(`SP_IDX_IEN, 8'h01);
      wr(`SP_IDX_SDATA, r.data);
      if (r.mode == 2'b00) begin
        u_serial_peer.get_sync(d, per);
        check("sync_oe", rxd_oe, 1'b1);
        check("sync_data", d, r.data);
        check("sync_per", per, r.per);
      end else if (r.mode == 2'b01) begin
        u_serial_peer.get(10, r.per, f);
        check("frame10", f, {2'b01, r.data, 1'b0});
      end else begin
        u_serial_peer.get(11, r.per, f);
        check("frame11", f, {1'b1, r.ninth, r.data, 1'b0});
      end
      repeat (16) @(posedge ref_clk);
      rd(`SP_IDX_SCTRL);
      check("tx_done", sc.tx_done_flag, 1'b1);
      check("irq_on", irq, 1'b1);
      wr(`SP_IDX_ICLR, 8'h07);
      wr(`SP_IDX_SCTRL, 8'h00);
      repeat (3) @(posedge ref_clk);
      check("irq_off", irq, 1'b0);
    end
    // Mode 2 with address filter, interrupt masked
    wr(`SP_IDX_PCTRL, 8'h00);
    wr(`SP_IDX_IEN, 8'h00);
    wr(`SP_IDX_SCTRL, 8'hB0);
    rx_frame({2'b10, 8'h00, 1'b0}, 11);
    check("ninth0_drop", sc.rx_done_flag, 1'b0);
    rx_frame({2'b11, 8'h33, 1'b0}, 11);
    check("addr_drop", sc.rx_done_flag, 1'b0);
    rx_frame({2'b11, 8'hFF, 1'b0}, 11);
    check("bcast_load", {sc.rx_done_flag, sc.ninth_rx_bit}, 2'b11);
    check("irq_masked", irq, 1'b0);
    rd(`SP_IDX_SDATA);
    check("rx_data", rdat, 32'hFF);
    // Mode 1, stop bit low, frame error detection on
    wr(`SP_IDX_SCTRL, 8'h50);
    wr(`SP_IDX_PCTRL, 8'h40);
    rx_frame({2'b00, 8'h96, 1'b0}, 10);
    check("fe_load", {sc[7], sc.rx_done_flag, sc.ninth_rx_bit}, 3'b110);
    rd(`SP_IDX_ISTAT);
    check("istat", rdat[2:1], 2'b11);
    wr(`SP_IDX_PCTRL, 8'h00);
    rd(`SP_IDX_SCTRL);
    check("mode_bits", rdat[7:6], 2'b01);
    // Reception disabled
    wr(`SP_IDX_SCTRL, 8'h40);
    rx_frame({2'b01, 8'h55, 1'b0}, 10);
    check("ren_off", sc.rx_done_flag, 1'b0);
    // Mode 0 receive started by enable rise
    wr(`SP_IDX_SCTRL, 8'h00);
    fork
      u_serial_peer.send_sync(8'h6B);
      wr(`SP_IDX_SCTRL, 8'h10);
    join
    repeat (16) @(posedge ref_clk);
    rd(`SP_IDX_SCTRL);
    check("sync_rx", {sc.rx_enable, sc.rx_done_flag}, 2'b11);
    rd(`SP_IDX_SDATA);
    check("sync_rx_data", rdat, 32'h6B);
    // Reset in mid-run clears control and status
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(`SP_IDX_SCTRL);
    check("sctrl_rst2", rdat, 32'h0);
    rd(`SP_IDX_ISTAT);
    check("istat_rst2", rdat, 32'h0);
    summarize();
  end
endmodule
